// File: design/charger_mode_switch_control.sv
// mode switch decoding, power path selection and indicator control
`timescale 1ns/100ps
`include "charger_defines.svh"
module charger_mode_switch_control
  import charger_types_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire pos_type     front_pos,
  input  wire pos_type     remote_pos,
  input  wire logic        remote_present,
  input  wire pos_type     panel_pos,
  input  wire logic        panel_present,
  input  wire logic        primary_ac_input_ok,
  input  wire logic        secondary_ac_input_ok,
  input  wire logic        load_exceeds_input,
  input  wire stage_type   charge_stage,
  input  wire logic        overload,
  input  wire logic        low_battery,
  input  wire logic        ripple_high,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic             inverter_on,
  output logic             primary_ac_input_relay,
  output logic             secondary_ac_input_relay,
  output logic             grid_only_ac_output_relay,
  output logic             charger_on,
  output logic             lamp_inverter,
  output logic             lamp_mains,
  output logic             lamp_bulk,
  output logic             lamp_absorption,
  output logic             lamp_float,
  output logic             lamp_overload,
  output logic             lamp_low_battery,
  output logic [1:0]       voltage_offset,
  output logic [7:0]       current_limit,
  output logic             equalising,
  output logic             forced_absorption
);
  if (TICK_CYCLES < 2) begin : bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
    for (int i = 0; i < 4; i++)
      merge_bytes[8*i +: 8] = be[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
  endfunction : merge_bytes

  // front must be on for remote and panel to act; off outranks charger-only
  function automatic pos_type combine_pos(input pos_type f, input pos_type r,
                                          input logic rp, input pos_type p,
                                          input logic pp);
    if (f != pos_on)
      combine_pos = f;
    else if ((rp && r == pos_off) || (pp && p == pos_off))
      combine_pos = pos_off;
    else if ((rp && r == pos_charger) || (pp && p == pos_charger))
      combine_pos = pos_charger;
    else
      combine_pos = pos_on;
  endfunction : combine_pos

  logic             ms_tick;
  logic             sec_tick;
  pos_type          pos;
  gesture_type      gstate;
  gesture_type      next_gstate;
  charge_mode_type  mode;
  logic [11:0]      gtime;
  logic [3:0]       bcnt;
  logic [15:0]      mtime;
  logic [7:0]       fcnt;
  logic             flash;
  logic             ripple_fault;
  logic [15:0]      control;
  logic [15:0]      abs_time;
  logic [7:0]       debounce;
  logic             sel_eq;
  logic             sel_fabs;
  logic             next_bulk;
  logic             next_abs;
  logic             next_float;

  rate_divider #(.DIVIDE(TICK_CYCLES)) ms_div (
    .mclk   (mclk),
    .reset  (reset),
    .enable (1'b1),
    .tick   (ms_tick)
  );

  rate_divider #(.DIVIDE(`MS_PER_S)) sec_div (
    .mclk   (mclk),
    .reset  (reset),
    .enable (ms_tick),
    .tick   (sec_tick)
  );

  wire pos_type raw_pos = combine_pos(front_pos, remote_pos, remote_present,
                                      panel_pos, panel_present);

  switch_position_filter filter (
    .mclk      (mclk),
    .reset     (reset),
    .ms_tick   (ms_tick),
    .raw_pos   (raw_pos),
    .threshold (debounce),
    .pos       (pos)
  );

  // register bus decode
  wire        req      = read | write;
  wire        hit_ctrl = address == `ADDR_CONTROL;
  wire        hit_abs  = address == `ADDR_ABS_TIME;
  wire        hit_deb  = address == `ADDR_DEBOUNCE;
  wire        hit_stat = address == `ADDR_STATUS;
  wire        commit   = write && !waitrequest;
  wire        bat24    = control[`CTRL_BAT24_BIT];
  wire [7:0]  charge_set = control[`CTRL_SET_LSB +: 8];
  wire [31:0] status   = {22'h000000, charger_on, ripple_fault, mode, gstate, pos};
  wire [31:0] read_mux = hit_ctrl ? {16'h0000, control} :
                         hit_abs  ? {16'h0000, abs_time} :
                         hit_deb  ? {24'h000000, debounce} :
                         hit_stat ? status : 32'h00000000;
  wire [31:0] merged   = merge_bytes(read_mux, writedata, byteenable);

  always_ff @(posedge mclk) begin
    if (reset) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
      control     <= `CONTROL_RST;
      abs_time    <= `ABS_TIME_RST;
      debounce    <= `DEBOUNCE_RST;
    end else begin
      waitrequest <= !(req && waitrequest);
      if (read && waitrequest)
        readdata <= read_mux;
      if (commit && hit_ctrl)
        control <= merged[15:0];
      if (commit && hit_abs)
        abs_time <= merged[15:0];
      if (commit && hit_deb)
        debounce <= merged[7:0];
    end
  end

  // power path
  wire ac_ok     = primary_ac_input_ok | secondary_ac_input_ok;
  wire passing   = ac_ok && pos != pos_off;
  wire next_inv  = !ripple_fault && pos == pos_on &&
                   (!ac_ok || load_exceeds_input);
  wire all_on    = front_pos == pos_on && (!remote_present || remote_pos == pos_on) &&
                   (!panel_present || panel_pos == pos_on);

  always_ff @(posedge mclk) begin
    if (reset)
      ripple_fault <= 1'b0;
    else if (ripple_high && pos != pos_off)
      ripple_fault <= 1'b1;
    else if (pos == pos_off)
      ripple_fault <= 1'b0;
  end

  // gesture recogniser
  wire in_window = gtime >= `INTERVAL_MIN_MS && gtime <= `INTERVAL_MAX_MS;
  wire late      = gtime > `INTERVAL_MAX_MS;
  wire half_done = ms_tick && gtime == `BLINK_HALF_MS - 12'h001;
  wire sel_done  = ms_tick && gtime == `SELECT_MS - 12'h001;

  always_comb begin
    next_gstate = gstate;
    sel_eq      = 1'b0;
    sel_fabs    = 1'b0;
    if (pos == pos_off)
      next_gstate = gst_idle;
    else unique case (gstate)
      gst_idle:
        if (all_on) next_gstate = gst_armed;
      gst_armed:
        if (pos == pos_charger) next_gstate = gst_first;
      gst_first:
        if (pos == pos_on) next_gstate = in_window ? gst_back : gst_idle;
        else if (late) next_gstate = gst_idle;
      gst_back:
        if (pos == pos_charger) next_gstate = in_window ? gst_blink : gst_idle;
        else if (late) next_gstate = gst_idle;
      gst_blink:
        if (half_done && bcnt == `BLINK_COUNT - 4'h1) next_gstate = gst_sel_bulk;
      gst_sel_bulk:
        if (pos == pos_on) begin
          sel_eq      = 1'b1;
          next_gstate = gst_idle;
        end else if (sel_done) next_gstate = gst_sel_abs;
      gst_sel_abs:
        if (pos == pos_on) begin
          sel_fabs    = 1'b1;
          next_gstate = gst_idle;
        end else if (sel_done) next_gstate = gst_sel_float;
      gst_sel_float:
        if (pos == pos_on || sel_done) next_gstate = gst_idle;
      default:
        next_gstate = gst_idle;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      gstate <= gst_idle;
      gtime  <= 12'h000;
      bcnt   <= 4'h0;
    end else begin
      gstate <= next_gstate;
      if (next_gstate != gstate || (gstate == gst_blink && half_done))
        gtime <= 12'h000;
      else if (ms_tick && gtime != `GTIME_MAX)
        gtime <= gtime + 12'h001;
      if (gstate != gst_blink)
        bcnt <= 4'h0;
      else if (half_done)
        bcnt <= bcnt + 4'h1;
    end
  end

  // charge mode timer in seconds
  wire [15:0] mode_limit = mode == mode_equalise ? `EQ_TIME_S : abs_time;

  always_ff @(posedge mclk) begin
    if (reset) begin
      mode  <= mode_normal;
      mtime <= 16'h0000;
    end else if (!passing) begin
      mode <= mode_normal;
    end else if (sel_eq || sel_fabs) begin
      mode  <= sel_eq ? mode_equalise : mode_forced_abs;
      mtime <= 16'h0000;
    end else if (sec_tick && mode != mode_normal) begin
      if (mtime >= mode_limit - 16'h0001)
        mode <= mode_normal;
      else
        mtime <= mtime + 16'h0001;
    end
  end

  // free-running flash phase for indicators
  always_ff @(posedge mclk) begin
    if (reset) begin
      fcnt  <= 8'h00;
      flash <= 1'b0;
    end else if (ms_tick) begin
      if (fcnt == 8'(`BLINK_HALF_MS - 12'h001)) begin
        fcnt  <= 8'h00;
        flash <= ~flash;
      end else begin
        fcnt <= fcnt + 8'h01;
      end
    end
  end

  // charge stage lamps
  always_comb begin
    next_bulk  = 1'b0;
    next_abs   = 1'b0;
    next_float = 1'b0;
    if (gstate == gst_blink) begin
      next_bulk  = ~bcnt[0];
      next_abs   = ~bcnt[0];
      next_float = ~bcnt[0];
    end else if (gstate == gst_sel_bulk || gstate == gst_sel_abs ||
                 gstate == gst_sel_float) begin
      next_bulk  = gstate == gst_sel_bulk;
      next_abs   = gstate == gst_sel_abs;
      next_float = gstate == gst_sel_float;
    end else if (passing) begin
      if (mode == mode_equalise) begin
        next_bulk = flash;
        next_abs  = ~flash;
      end else if (mode == mode_forced_abs) begin
        next_abs = 1'b1;
      end else begin
        unique case (charge_stage)
          stage_bulk:       next_bulk  = 1'b1;
          stage_absorption: next_abs   = 1'b1;
          default:          next_float = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      inverter_on               <= 1'b0;
      primary_ac_input_relay    <= 1'b0;
      secondary_ac_input_relay  <= 1'b0;
      grid_only_ac_output_relay <= 1'b0;
      charger_on                <= 1'b0;
      lamp_inverter             <= 1'b0;
      lamp_mains                <= 1'b0;
      lamp_bulk                 <= 1'b0;
      lamp_absorption           <= 1'b0;
      lamp_float                <= 1'b0;
      lamp_overload             <= 1'b0;
      lamp_low_battery          <= 1'b0;
      voltage_offset            <= 2'h0;
      current_limit             <= 8'h00;
      equalising                <= 1'b0;
      forced_absorption         <= 1'b0;
    end else begin
      inverter_on               <= next_inv;
      lamp_inverter             <= next_inv;
      primary_ac_input_relay    <= passing && primary_ac_input_ok;
      secondary_ac_input_relay  <= passing && !primary_ac_input_ok;
      grid_only_ac_output_relay <= passing;
      charger_on                <= passing;
      lamp_mains                <= passing;
      lamp_bulk                 <= next_bulk;
      lamp_absorption           <= next_abs;
      lamp_float                <= next_float;
      lamp_overload             <= ripple_fault ? flash : overload;
      lamp_low_battery          <= ripple_fault ? flash : low_battery;
      voltage_offset            <= mode != mode_equalise ? 2'h0 :
                                   bat24 ? `EQ_OFFSET_24V : `EQ_OFFSET_12V;
      current_limit             <= mode == mode_equalise ? {2'h0, charge_set[7:2]} :
                                   charge_set;
      equalising                <= mode == mode_equalise;
      forced_absorption         <= mode == mode_forced_abs;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_on_no_ac: assert property (pos == pos_on && !ac_ok && !ripple_fault
    |=> inverter_on && lamp_inverter) else $error("inverter not started");
  a_pass_inv_off: assert property (pos == pos_on && ac_ok && !load_exceeds_input
    |=> !inverter_on && lamp_mains && charger_on) else $error("pass-through wrong");
  a_charger_only: assert property (pos == pos_charger
    |=> !inverter_on) else $error("inverter ran in charger-only");
  a_primary_pick: assert property (pos != pos_off && primary_ac_input_ok
    |=> primary_ac_input_relay && !secondary_ac_input_relay) else $error("bad source");
  a_stage_onehot: assert property (passing && mode == mode_normal && gstate <= gst_back
    |=> $onehot({lamp_bulk, lamp_absorption, lamp_float})) else $error("stage lamps");
  a_eq_limit: assert property (mode == mode_equalise
    |=> current_limit == {2'h0, $past(charge_set[7:2])}) else $error("eq limit");
  a_eq_offset: assert property (mode == mode_equalise && bat24
    |=> voltage_offset == `EQ_OFFSET_24V) else $error("eq offset");
  a_eq_alternate: assert property (passing && mode == mode_equalise && gstate <= gst_back
    |=> lamp_bulk != lamp_absorption) else $error("eq lamps not alternating");
  a_fabs_steady: assert property (passing && mode == mode_forced_abs && gstate <= gst_back
    |=> lamp_absorption && !lamp_bulk) else $error("forced absorption lamp");
  a_ripple_flash: assert property (ripple_fault
    |=> !inverter_on && lamp_overload == lamp_low_battery) else $error("ripple");
  a_off_abort: assert property (pos == pos_off
    |=> gstate == gst_idle) else $error("gesture not abandoned");
  a_select_eq: assert property (gstate == gst_sel_bulk && pos == pos_on && passing
    |=> mode == mode_equalise ##1 equalising) else $error("equalise not entered");

  c_gesture_blink: cover property (gstate == gst_back ##1 gstate == gst_blink);
  c_enter_eq: cover property (mode == mode_normal ##1 mode == mode_equalise);
  c_enter_fabs: cover property (mode == mode_normal ##1 mode == mode_forced_abs);
  c_assist: cover property (ac_ok && load_exceeds_input && inverter_on);
endmodule : charger_mode_switch_control

// File: design/charger_defines.svh
// offsets, field positions, reset values and timing counts of the mode controller
`ifndef CHARGER_DEFINES_SVH
`define CHARGER_DEFINES_SVH

// clock and tick timing
`define CLK_PERIOD_NS    32'h0000000a
`define TICK_PERIOD_NS   32'h000f4240
`define TICK_CYCLES      (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define MS_PER_S         32'h000003e8

// gesture timing in milliseconds, and the number of blink half-periods
`define INTERVAL_MIN_MS  12'h1f4
`define INTERVAL_MAX_MS  12'h7d0
`define BLINK_HALF_MS    12'h0fa
`define BLINK_COUNT      4'ha
`define SELECT_MS        12'h7d0
`define GTIME_MAX        12'hfff

// equalisation timing in seconds and voltage offsets in volts
`define EQ_TIME_S        16'h0e10
`define EQ_OFFSET_12V    2'h1
`define EQ_OFFSET_24V    2'h2

// register byte addresses
`define ADDR_CONTROL     4'h0
`define ADDR_ABS_TIME    4'h4
`define ADDR_DEBOUNCE    4'h8
`define ADDR_STATUS      4'hc

// control register fields
`define CTRL_BAT24_BIT   0
`define CTRL_SET_LSB     8

// reset values
`define CONTROL_RST      16'h4000
`define ABS_TIME_RST     16'h1c20
`define DEBOUNCE_RST     8'h32

`endif

// File: design/charger_types_pkg.sv
// types shared by the mode controller files
package charger_types_pkg;

  typedef enum logic [1:0] {
    pos_off     = 2'h0,
    pos_on      = 2'h1,
    pos_charger = 2'h2
  } pos_type;

  typedef enum logic [1:0] {
    stage_bulk       = 2'h0,
    stage_absorption = 2'h1,
    stage_float      = 2'h2
  } stage_type;

  typedef enum logic [1:0] {
    mode_normal     = 2'h0,
    mode_equalise   = 2'h1,
    mode_forced_abs = 2'h2
  } charge_mode_type;

  typedef enum logic [3:0] {
    gst_idle      = 4'h0,
    gst_armed     = 4'h1,
    gst_first     = 4'h2,
    gst_back      = 4'h3,
    gst_blink     = 4'h4,
    gst_sel_bulk  = 4'h5,
    gst_sel_abs   = 4'h6,
    gst_sel_float = 4'h7
  } gesture_type;

endpackage : charger_types_pkg

// File: design/rate_divider.sv
// enable divider: one tick pulse every DIVIDE enabled cycles
`timescale 1ns/100ps
module rate_divider #(
  parameter int DIVIDE = 1000
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic enable,
  output logic      tick
);
  localparam int CW = $clog2(DIVIDE);

  if (DIVIDE < 2) begin : bad_divide
    $error("rate_divider needs DIVIDE of at least 2");
  end

  logic [CW-1:0] count;
  wire           wrap = enable && (count == CW'(DIVIDE - 1));

  always_ff @(posedge mclk) begin
    if (reset) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      tick <= wrap;
      if (wrap)
        count <= '0;
      else if (enable)
        count <= count + 1'b1;
    end
  end
endmodule : rate_divider

// File: design/switch_position_filter.sv
// switch position filter that hides short dwells in the off position
`timescale 1ns/100ps
module switch_position_filter
  import charger_types_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       ms_tick,
  input  wire pos_type    raw_pos,
  input  wire logic [7:0] threshold,
  output pos_type         pos
);
  logic [7:0] dwell;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pos   <= pos_off;
      dwell <= 8'h00;
    end else if (raw_pos != pos_off) begin
      pos   <= raw_pos;
      dwell <= 8'h00;
    end else if (dwell >= threshold) begin
      pos <= pos_off;
    end else if (ms_tick) begin
      dwell <= dwell + 8'h01;
    end
  end
endmodule : switch_position_filter

// File: verification/mode_switch_model.sv
// behavioural model of the front mode switch worked by an operator
`timescale 1ns/100ps
module mode_switch_model
  import charger_types_pkg::*;
#(
  parameter int MS_CYCLES = 2
) (
  input  wire logic mclk,
  output pos_type   pos
);
  initial begin
    pos = pos_off;
  end

  // move to a position and dwell there for ms milliseconds
  task automatic hold(input pos_type p, input int ms);
    @(posedge mclk);
    pos <= p;
    repeat (ms * MS_CYCLES - 1) @(posedge mclk);
  endtask : hold

  // charger-only, on, charger-only with quick passes through off
  task automatic gesture();
    hold(pos_charger, 800);
    hold(pos_off, 5);
    hold(pos_on, 800);
    hold(pos_off, 5);
    hold(pos_charger, 1);
  endtask : gesture
endmodule : mode_switch_model

// File: verification/testbench.sv
// self-checking bench for the mode switch controller
`timescale 1ns/100ps
module testbench
  import charger_types_pkg::*;
;
  localparam int TICK = 2;
  logic        mclk, reset, rem_present, ac1_ok, ac2_ok, load_high, ripple, read, write;
  pos_type     front_pos, rem_pos;
  stage_type   stage;
  logic [3:0]  address;
  logic [31:0] writedata, readdata, d;
  logic        waitrequest, inverter_on, relay1, relay2, relay_grid, charger_on;
  logic        l_inv, l_mains, l_bulk, l_abs, l_float, l_ovl, l_lowbat, eq, fabs;
  logic [1:0]  voltage_offset;
  logic [7:0]  current_limit;
  int          n_mismatch, cmp_count;

  mode_switch_model #(.MS_CYCLES(TICK)) i_switch (.mclk(mclk), .pos(front_pos));

  charger_mode_switch_control #(.TICK_CYCLES(TICK)) i_dut (
    .mclk(mclk), .reset(reset), .front_pos(front_pos), .remote_pos(rem_pos),
    .remote_present(rem_present), .panel_pos(pos_on), .panel_present(1'b0),
    .primary_ac_input_ok(ac1_ok), .secondary_ac_input_ok(ac2_ok),
    .load_exceeds_input(load_high), .charge_stage(stage), .overload(1'b0),
    .low_battery(1'b0), .ripple_high(ripple), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
    .waitrequest(waitrequest), .inverter_on(inverter_on), .primary_ac_input_relay(relay1),
    .secondary_ac_input_relay(relay2), .grid_only_ac_output_relay(relay_grid),
    .charger_on(charger_on), .lamp_inverter(l_inv), .lamp_mains(l_mains),
    .lamp_bulk(l_bulk), .lamp_absorption(l_abs), .lamp_float(l_float),
    .lamp_overload(l_ovl), .lamp_low_battery(l_lowbat), .voltage_offset(voltage_offset),
    .current_limit(current_limit), .equalising(eq), .forced_absorption(fabs));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic results();
    if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wait_ms(input int ms);
    repeat (ms * TICK) @(posedge mclk);
  endtask : wait_ms

  // one bus access: hold the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int i;
    @(posedge mclk);
    read      <= ~wr;
    write     <= wr;
    address   <= a;
    writedata <= wd;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (waitrequest !== 1'b0 && i < 50);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (i >= 50) begin
      n_mismatch++;
      results();
    end
  endtask : bus

  initial begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    results();
  end

  initial begin
    {reset, rem_present, ac1_ok, ac2_ok, load_high, ripple, read, write} = 8'h80;
    rem_pos = pos_on;
    stage = stage_bulk;
    address = 4'h0;
    writedata = 32'h0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    bus(1'b0, 4'h0, 32'h0, d);
    check("control", d, 32'h4000);
    bus(1'b0, 4'h4, 32'h0, d);
    check("abs_time", d, 32'h1c20);
    bus(1'b0, 4'h8, 32'h0, d);
    check("debounce", d, 32'h32);
    bus(1'b0, 4'h1, 32'h0, d);
    check("unmapped", d, 32'h0);
    // inverter path with no accepted input
    i_switch.hold(pos_on, 5);
    check("inv_on", {inverter_on, l_inv, relay1, relay_grid}, 32'hc);
    ac1_ok <= 1'b1;
    ac2_ok <= 1'b1;
    wait_ms(2);
    check("relays", {relay1, relay2, relay_grid}, 32'h5);
    check("mains", {inverter_on, charger_on, l_mains, l_inv}, 32'h6);
    for (int s = 0; s < 3; s++) begin
      stage <= stage_type'(s);
      wait_ms(2);
      check("stage_lamps", {l_bulk, l_abs, l_float}, 32'h4 >> s);
    end
    load_high <= 1'b1;
    wait_ms(2);
    check("assist", inverter_on, 32'h1);
    load_high <= 1'b0;
    i_switch.hold(pos_charger, 5);
    ac1_ok <= 1'b0;
    ac2_ok <= 1'b0;
    wait_ms(2);
    check("charger_only", {inverter_on, relay_grid}, 32'h0);
    i_switch.hold(pos_on, 5);
    ripple <= 1'b1;
    @(posedge mclk);
    ripple <= 1'b0;
    wait_ms(2);
    check("ripple_inv", inverter_on, 32'h0);
    d = {31'h0, l_ovl};
    check("ripple_pair", l_lowbat, d);
    wait_ms(250);
    check("ripple_flash", {l_ovl, l_lowbat}, {30'h0, ~d[0], ~d[0]});
    i_switch.hold(pos_off, 100);
    // equalisation at 24 V with setting 0x40
    bus(1'b1, 4'h0, 32'h4001, d);
    ac1_ok <= 1'b1;
    stage <= stage_float;
    i_switch.hold(pos_on, 10);
    i_switch.gesture();
    wait_ms(100);
    check("blink", {l_bulk, l_abs, l_float}, 32'h7);
    wait_ms(3400);
    check("sel_bulk", {l_bulk, l_abs, l_float}, 32'h4);
    i_switch.hold(pos_on, 10);
    check("eq", {eq, fabs, voltage_offset, current_limit}, 32'ha10);
    check("eq_lamps", l_bulk ^ l_abs, 32'h1);
    ac1_ok <= 1'b0;
    wait_ms(10);
    ac1_ok <= 1'b1;
    // forced absorption at 12 V
    bus(1'b1, 4'h0, 32'h4000, d);
    i_switch.hold(pos_on, 10);
    i_switch.gesture();
    wait_ms(5500);
    check("sel_abs", {l_bulk, l_abs, l_float}, 32'h2);
    i_switch.hold(pos_on, 10);
    check("fabs", {eq, fabs, voltage_offset, l_abs}, 32'h9);
    wait_ms(300);
    check("fabs_steady", {fabs, l_abs, l_bulk}, 32'h6);
    // refused with a remote at charger-only, then abandoned by an off dwell
    i_switch.hold(pos_off, 100);
    rem_present <= 1'b1;
    rem_pos <= pos_charger;
    i_switch.hold(pos_on, 20);
    bus(1'b0, 4'hc, 32'h0, d);
    check("refused", {26'h0, d[5:0]}, 32'h2);
    rem_present <= 1'b0;
    i_switch.hold(pos_on, 10);
    i_switch.hold(pos_charger, 800);
    bus(1'b0, 4'hc, 32'h0, d);
    check("first", {28'h0, d[5:2]}, 32'h2);
    i_switch.hold(pos_off, 100);
    bus(1'b0, 4'hc, 32'h0, d);
    check("abandon", {26'h0, d[5:0]}, 32'h0);
    // window passes unused, a quick change afterwards selects nothing
    i_switch.hold(pos_on, 10);
    i_switch.gesture();
    wait_ms(7500);
    check("sel_float", {l_bulk, l_abs, l_float}, 32'h1);
    wait_ms(1200);
    i_switch.hold(pos_off, 5);
    i_switch.hold(pos_on, 10);
    check("late_on", {eq, fabs, l_abs}, 32'h0);
    results();
  end
endmodule : testbench
